// >>> lld_pkg.sv
// constants for the link-layer diagnostic and timing register bank
package lld_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam logic [31:0] OFS_SLEEP_CONTROL   = 32'h4000_0030;
   localparam logic [31:0] OFS_FINE_CORR       = 32'h4000_0040;
   localparam logic [31:0] OFS_BASE_CORR       = 32'h4000_0044;
   localparam logic [31:0] OFS_DEBUG_CONTROL   = 32'h4000_0050;
   localparam logic [31:0] OFS_DEBUG_READBACK  = 32'h4000_0054;
   localparam logic [31:0] OFS_ZONE_UPPER      = 32'h4000_0058;
   localparam logic [31:0] OFS_ZONE_LOWER      = 32'h4000_005c;
   localparam logic [31:0] OFS_ERROR_FLAGS     = 32'h4000_0060;
   localparam logic [31:0] OFS_SW_PROFILE      = 32'h4000_0064;
   localparam int APPLY_CORR_BIT = 3;
   localparam int FINE_W         = 10;
   localparam int BASE_W         = 27;
   localparam int DBG_PORTS      = 4;
   localparam int DBG_STRIDE     = 8;
   localparam int DBG_SEL_W      = 6;
   localparam int DBG_EN_POS     = 7;
   localparam int ZONE_W         = 16;
   localparam int REG_ZONE_LSB   = 16;
   localparam int EM_ZONE_LSB    = 0;
   localparam int FAULT_LSB      = 10;
   localparam int FAULT_W        = 8;
   // fault vector positions, relative to FAULT_LSB
   localparam int F_ADVERTISING_INTERVAL_UNDERRUN = 0;
   localparam int F_CHMAP        = 1;
   localparam int F_CS_FORMAT    = 2;
   localparam int F_TX_DESC      = 3;
   localparam int F_RX_DESC      = 4;
   localparam int F_TX_BUF       = 5;
   localparam int F_RX_BUF       = 6;
   localparam int F_UNACKED_IRQ  = 7;
   localparam int CHMAP_W        = 37;
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
   // debug selector codes
   localparam logic [5:0] SEL_PROFILE_B0 = 6'h00;
   localparam logic [5:0] SEL_PROFILE_B1 = 6'h01;
   localparam logic [5:0] SEL_PROFILE_B2 = 6'h02;
   localparam logic [5:0] SEL_PROFILE_B3 = 6'h03;
   localparam logic [5:0] SEL_FAULTS     = 6'h04;
   localparam logic [5:0] SEL_STATUS     = 6'h05;
   localparam logic [5:0] SEL_FINE_LOW   = 6'h06;
   localparam logic [5:0] SEL_BASE_LOW   = 6'h07;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// >>> lld_diag_timing_regs.sv
// link-layer timing correction, debug port and fault flag register bank
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module lld_diag_timing_regs (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          clk_en,
   input  wire logic [lld_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [lld_pkg::DATA_W-1:0]    s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [lld_pkg::ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [lld_pkg::DATA_W-1:0]         s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   output logic [lld_pkg::FINE_W-1:0]         fine_phase_correction,
   output logic [lld_pkg::BASE_W-1:0]         base_time_correction_value,
   output logic                               apply_sleep_correction,
   output logic [7:0]                         debug_out0,
   output logic [7:0]                         debug_out1,
   output logic [7:0]                         debug_out2,
   output logic [7:0]                         debug_out3,
   input  wire logic [lld_pkg::ZONE_W-1:0]    reg_access_addr,
   input  wire logic                          reg_access_valid,
   output logic                               register_zone_hit,
   input  wire logic [lld_pkg::ZONE_W-1:0]    em_access_addr,
   input  wire logic                          em_access_valid,
   output logic                               exchange_zone_hit,
   input  wire logic                          event_irq,
   input  wire logic                          event_irq_ack,
   input  wire logic [15:0]                   rx_buffer_ptr,
   input  wire logic                          rx_buffer_check,
   input  wire logic [15:0]                   tx_buffer_ptr,
   input  wire logic                          tx_buffer_check,
   input  wire logic [7:0]                    tx_packet_length,
   input  wire logic                          event_is_adv_scan_init,
   input  wire logic                          event_is_connection,
   input  wire logic [14:0]                   rx_descriptor_ptr,
   input  wire logic                          rx_descriptor_check,
   input  wire logic [14:0]                   tx_descriptor_ptr,
   input  wire logic                          tx_descriptor_check,
   input  wire logic                          control_format_invalid,
   input  wire logic [lld_pkg::CHMAP_W-1:0]   control_channel_map,
   input  wire logic [5:0]                    good_channel_count,
   input  wire logic                          hop_start,
   input  wire logic                          advertising_interval_underrun
);
   import lld_pkg::*;

   logic [ADDR_W-1:0]   aw_addr_reg;
   logic                aw_held_reg;
   logic [DATA_W-1:0]   w_data_reg;
   logic [3:0]          w_strb_reg;
   logic                w_held_reg;
   logic                wr_do;
   logic                aw_take;
   logic                w_take;
   logic                ar_take;
   logic                wr_hit;
   logic [DATA_W-1:0]   rd_word;
   logic                rd_hit;
   logic [FINE_W-1:0]   fine_reg;
   logic [BASE_W-1:0]   base_reg;
   logic [DATA_W-1:0]   dbg_ctl_reg;
   logic [DATA_W-1:0]   zone_upper_reg;
   logic [DATA_W-1:0]   zone_lower_reg;
   logic [DATA_W-1:0]   profile_reg;
   logic                corr_pending_reg;
   logic                apply_reg;
   logic [FAULT_W-1:0]  fault_reg;
   logic [FAULT_W-1:0]  fault_set;
   logic                irq_pending_reg;
   logic [7:0]          dbg_reg [DBG_PORTS];
   logic                reg_hit_reg;
   logic                em_hit_reg;
   logic [7:0]          status_byte;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, new_v,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [6:0] ones_count(input logic [CHMAP_W-1:0] map);
      logic [6:0] n;
      n = 7'h00;
      for (int c = 0; c < CHMAP_W; c++) begin
         n = n + {6'h00, map[c]};
      end
      return n;
   endfunction

   function automatic logic in_zone(input logic [ZONE_W-1:0] addr, low, high);
      return (addr >= low) && (addr <= high);
   endfunction

   function automatic logic [7:0] dbg_pick(input logic [5:0]  sel,
                                           input logic [31:0] prof,
                                           input logic [7:0]  faults, stat, fine_lo, base_lo);
      logic [7:0] v;
      case (sel)
         SEL_PROFILE_B0: v = prof[7:0];
         SEL_PROFILE_B1: v = prof[15:8];
         SEL_PROFILE_B2: v = prof[23:16];
         SEL_PROFILE_B3: v = prof[31:24];
         SEL_FAULTS:     v = faults;
         SEL_STATUS:     v = stat;
         SEL_FINE_LOW:   v = fine_lo;
         SEL_BASE_LOW:   v = base_lo;
         default:        v = 8'h00;
      endcase
      return v;
   endfunction

   // bus handshakes
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take  = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign wr_do   = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_hit  = (aw_addr_reg == OFS_SLEEP_CONTROL) || (aw_addr_reg == OFS_FINE_CORR)
                 || (aw_addr_reg == OFS_BASE_CORR) || (aw_addr_reg == OFS_DEBUG_CONTROL)
                 || (aw_addr_reg == OFS_DEBUG_READBACK) || (aw_addr_reg == OFS_ZONE_UPPER)
                 || (aw_addr_reg == OFS_ZONE_LOWER) || (aw_addr_reg == OFS_ERROR_FLAGS)
                 || (aw_addr_reg == OFS_SW_PROFILE);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         aw_held_reg   <= 1'b0;
         aw_addr_reg   <= RESET_VALUE;
         s_axi_awready <= 1'b1;
      end else if (clk_en) begin
         if (aw_take) begin
            aw_held_reg   <= 1'b1;
            aw_addr_reg   <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_do) begin
            aw_held_reg   <= 1'b0;
            s_axi_awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         w_held_reg   <= 1'b0;
         w_data_reg   <= RESET_VALUE;
         w_strb_reg   <= 4'h0;
         s_axi_wready <= 1'b1;
      end else if (clk_en) begin
         if (w_take) begin
            w_held_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_do) begin
            w_held_reg   <= 1'b0;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (clk_en) begin
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // writable registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fine_reg       <= FINE_W'(RESET_VALUE);
         base_reg       <= BASE_W'(RESET_VALUE);
         dbg_ctl_reg    <= RESET_VALUE;
         zone_upper_reg <= RESET_VALUE;
         zone_lower_reg <= RESET_VALUE;
         profile_reg    <= RESET_VALUE;
      end else if (clk_en && wr_do) begin
         case (aw_addr_reg)
            OFS_FINE_CORR: begin
               fine_reg <= FINE_W'(merge_bytes({22'h0, fine_reg}, w_data_reg, w_strb_reg));
            end
            OFS_BASE_CORR: begin
               base_reg <= BASE_W'(merge_bytes({5'h0, base_reg}, w_data_reg, w_strb_reg));
            end
            OFS_DEBUG_CONTROL: dbg_ctl_reg <= merge_bytes(dbg_ctl_reg, w_data_reg, w_strb_reg);
            OFS_ZONE_UPPER: zone_upper_reg <= merge_bytes(zone_upper_reg, w_data_reg, w_strb_reg);
            OFS_ZONE_LOWER: zone_lower_reg <= merge_bytes(zone_lower_reg, w_data_reg, w_strb_reg);
            OFS_SW_PROFILE: profile_reg <= merge_bytes(profile_reg, w_data_reg, w_strb_reg);
            default: ;
         endcase
      end
   end

   // correction apply: pending one cycle, then one pulse, bit reads back the pending flag
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         corr_pending_reg <= 1'b0;
         apply_reg        <= 1'b0;
      end else if (clk_en) begin
         apply_reg <= corr_pending_reg;
         if (wr_do && aw_addr_reg == OFS_SLEEP_CONTROL && w_strb_reg[0]
             && w_data_reg[APPLY_CORR_BIT]) begin
            corr_pending_reg <= 1'b1;
         end else begin
            corr_pending_reg <= 1'b0;
         end
      end
   end

   // fault detection
   always_comb begin
      fault_set = '0;
      fault_set[F_UNACKED_IRQ]  = event_irq && irq_pending_reg && !event_irq_ack;
      fault_set[F_RX_BUF]       = rx_buffer_check && (rx_buffer_ptr == 16'h0000);
      fault_set[F_TX_BUF]       = tx_buffer_check && (tx_buffer_ptr == 16'h0000)
                                  && (event_is_adv_scan_init
                                      || (event_is_connection && tx_packet_length != 8'h00));
      fault_set[F_RX_DESC]      = rx_descriptor_check && (rx_descriptor_ptr == 15'h0000);
      fault_set[F_TX_DESC]      = tx_descriptor_check && (tx_descriptor_ptr == 15'h0000)
                                  && event_is_adv_scan_init;
      fault_set[F_CS_FORMAT]    = control_format_invalid;
      fault_set[F_CHMAP]        = hop_start
                                  && (ones_count(control_channel_map) != {1'b0, good_channel_count});
      fault_set[F_ADVERTISING_INTERVAL_UNDERRUN] = advertising_interval_underrun;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_pending_reg <= 1'b0;
      end else if (clk_en) begin
         if (event_irq) begin
            irq_pending_reg <= 1'b1;
         end else if (event_irq_ack) begin
            irq_pending_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fault_reg <= '0;
      end else if (clk_en) begin
         fault_reg <= fault_reg | fault_set;
      end
   end

   // debug ports
   assign status_byte = {4'h0, reg_hit_reg, em_hit_reg, irq_pending_reg, corr_pending_reg};

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int p = 0; p < DBG_PORTS; p++) begin
            dbg_reg[p] <= 8'h00;
         end
      end else if (clk_en) begin
         for (int p = 0; p < DBG_PORTS; p++) begin
            if (dbg_ctl_reg[p*DBG_STRIDE + DBG_EN_POS]) begin
               dbg_reg[p] <= dbg_pick(dbg_ctl_reg[p*DBG_STRIDE +: DBG_SEL_W], profile_reg,
                                      fault_reg, status_byte, fine_reg[7:0],
                                      base_reg[7:0]);
            end else begin
               dbg_reg[p] <= 8'h00;
            end
         end
      end
   end

   // access zone flags
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reg_hit_reg <= 1'b0;
         em_hit_reg  <= 1'b0;
      end else if (clk_en) begin
         reg_hit_reg <= reg_access_valid
                        && in_zone(reg_access_addr, zone_lower_reg[REG_ZONE_LSB +: ZONE_W],
                                   zone_upper_reg[REG_ZONE_LSB +: ZONE_W]);
         em_hit_reg  <= em_access_valid
                        && in_zone(em_access_addr, zone_lower_reg[EM_ZONE_LSB +: ZONE_W],
                                   zone_upper_reg[EM_ZONE_LSB +: ZONE_W]);
      end
   end

   // read path
   always_comb begin
      rd_word = RESET_VALUE;
      rd_hit  = 1'b1;
      case (s_axi_araddr)
         OFS_SLEEP_CONTROL:  rd_word[APPLY_CORR_BIT] = corr_pending_reg;
         OFS_FINE_CORR:      rd_word[FINE_W-1:0] = fine_reg;
         OFS_BASE_CORR:      rd_word[BASE_W-1:0] = base_reg;
         OFS_DEBUG_CONTROL:  rd_word = dbg_ctl_reg;
         OFS_DEBUG_READBACK: rd_word = {dbg_reg[3], dbg_reg[2], dbg_reg[1], dbg_reg[0]};
         OFS_ZONE_UPPER:     rd_word = zone_upper_reg;
         OFS_ZONE_LOWER:     rd_word = zone_lower_reg;
         OFS_ERROR_FLAGS:    rd_word[FAULT_LSB +: FAULT_W] = fault_reg;
         OFS_SW_PROFILE:     rd_word = profile_reg;
         default:            rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= RESET_VALUE;
         s_axi_rresp   <= RESP_OKAY;
      end else if (clk_en) begin
         if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_DECERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
         end
      end
   end

   assign fine_phase_correction      = fine_reg;
   assign base_time_correction_value = base_reg;
   assign apply_sleep_correction     = apply_reg;
   assign debug_out0                 = dbg_reg[0];
   assign debug_out1                 = dbg_reg[1];
   assign debug_out2                 = dbg_reg[2];
   assign debug_out3                 = dbg_reg[3];
   assign register_zone_hit          = reg_hit_reg;
   assign exchange_zone_hit          = em_hit_reg;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_corr_write;
      clk_en && wr_do && aw_addr_reg == OFS_SLEEP_CONTROL && w_strb_reg[0]
      && w_data_reg[APPLY_CORR_BIT];
   endsequence

   sequence s_corr_done;
      corr_pending_reg && !apply_reg ##1 apply_reg && !corr_pending_reg;
   endsequence

   a_fine_after_reset: assert property ($rose(reset_n) |-> fine_reg == 10'h000)
      else $error("fine correction not zero after reset");
   a_base_write_lands: assert property (clk_en && wr_do && aw_addr_reg == OFS_BASE_CORR
         && w_strb_reg == 4'hf |=> base_reg == $past(w_data_reg[26:0]))
      else $error("base correction write lost");
   a_corr_self_clear: assert property (s_corr_write ##1 clk_en |-> ##0 s_corr_done)
      else $error("correction apply did not pulse and clear");
   a_port_off_zero: assert property (clk_en && !dbg_ctl_reg[DBG_EN_POS] |=> debug_out0 == 8'h00)
      else $error("disabled debug port not zero");
   a_sel_unmapped: assert property (clk_en && dbg_ctl_reg[31] && dbg_ctl_reg[29:24] > 6'h07
         |=> debug_out3 == 8'h00)
      else $error("unassigned selector drove nonzero");
   a_profile_copy: assert property (clk_en && dbg_ctl_reg[23] && dbg_ctl_reg[21:16] == 6'h03
         |=> debug_out2 == $past(profile_reg[31:24]))
      else $error("profile byte not on debug port");
   a_readback_match: assert property (clk_en && ar_take && s_axi_araddr == OFS_DEBUG_READBACK
         |=> s_axi_rvalid && s_axi_rdata == $past({debug_out3, debug_out2, debug_out1,
                                                     debug_out0}))
      else $error("readback word differs from debug ports");
   a_zone_em_hit: assert property (clk_en && em_access_valid
         && em_access_addr >= zone_lower_reg[15:0] && em_access_addr <= zone_upper_reg[15:0]
         |=> exchange_zone_hit)
      else $error("exchange zone hit missing");
   a_zone_reg_miss: assert property (clk_en && reg_access_valid
         && reg_access_addr > zone_upper_reg[31:16] |=> !register_zone_hit)
      else $error("register zone hit above upper limit");
   a_chmap_fault: assert property (clk_en && hop_start
         && ones_count(control_channel_map) != {1'b0, good_channel_count}
         |=> fault_reg[F_CHMAP])
      else $error("channel map mismatch not flagged");
   a_fault_sticky: assert property (fault_reg[F_RX_BUF] |=> fault_reg[F_RX_BUF])
      else $error("fault flag cleared without reset");
endmodule

// >>> tb_top.sv
// self-checking testbench for the link-layer diagnostic and timing register bank
`timescale 1ns/1ps
module tb_top;
   import lld_pkg::*;
   logic        clk = 0, reset_n = 0, clk_en = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid, apply;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
   logic [1:0]  bresp, rresp;
   logic [9:0]  fine;
   logic [26:0] base;
   logic [7:0]  d0, d1, d2, d3, tx_len = 0;
   logic [15:0] reg_a = 0, em_a = 0, rx_bp = 16'h0100, tx_bp = 16'h0200;
   logic [14:0] rx_dp = 15'h0100, tx_dp = 15'h0200;
   logic        reg_hit, em_hit, irq = 0, ack = 0, rx_bc = 0, tx_bc = 0, adv = 0, conn = 0;
   logic        rx_dc = 0, tx_dc = 0, cs_bad = 0, hop = 0, und = 0, zv = 0;
   logic [36:0] chmap = 37'h7;
   logic [5:0]  ngood = 6'h03;
   logic [3:0]  strb = 4'hf;
   int          fail_count = 0, cmp_count = 0, pulses = 0;
   lld_diag_timing_regs u_lld_diag_timing_regs (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .fine_phase_correction(fine), .base_time_correction_value(base),
      .apply_sleep_correction(apply), .debug_out0(d0), .debug_out1(d1), .debug_out2(d2),
      .debug_out3(d3), .reg_access_addr(reg_a), .reg_access_valid(zv),
      .register_zone_hit(reg_hit), .em_access_addr(em_a), .em_access_valid(zv),
      .exchange_zone_hit(em_hit), .event_irq(irq), .event_irq_ack(ack),
      .rx_buffer_ptr(rx_bp), .rx_buffer_check(rx_bc), .tx_buffer_ptr(tx_bp),
      .tx_buffer_check(tx_bc), .tx_packet_length(tx_len), .event_is_adv_scan_init(adv),
      .event_is_connection(conn), .rx_descriptor_ptr(rx_dp), .rx_descriptor_check(rx_dc),
      .tx_descriptor_ptr(tx_dp), .tx_descriptor_check(tx_dc), .control_format_invalid(cs_bad),
      .control_channel_map(chmap), .good_channel_count(ngood), .hop_start(hop),
      .advertising_interval_underrun(und));
   always #4 clk = ~clk;
   always @(posedge clk) if (apply === 1'b1) pulses <= pulses + 1;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
         fail_count++;
      end
   endtask
   // ready and valid are registered, so the level seen at the falling edge is what the next edge takes
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
      logic aw = 0, w = 0, b = 0;
      int   n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!b && n < 200) begin
         @(negedge clk);
         aw = awvalid & awready;
         w = wvalid & wready;
         b = bvalid;
         @(posedge clk);
         if (aw) awvalid <= 0;
         if (w) wvalid <= 0;
         n++;
      end
      bready <= 0;
      if (!b) fail_count++;
      chk(bresp, e);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
      logic t = 0, r = 0;
      int   n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      while (!r && n < 200) begin
         @(negedge clk);
         t = arvalid & arready;
         r = rvalid;
         @(posedge clk);
         if (t) arvalid <= 0;
         n++;
      end
      rready <= 0;
      if (!r) fail_count++;
      chk(rdata, e);
      chk(rresp, er);
   endtask
   task automatic t_reset;
      logic [31:0] ofs[7] = '{OFS_FINE_CORR, OFS_BASE_CORR, OFS_DEBUG_CONTROL,
         OFS_DEBUG_READBACK, OFS_ZONE_UPPER, OFS_ZONE_LOWER, OFS_ERROR_FLAGS};
      foreach (ofs[i]) rd(ofs[i], 32'h0, RESP_OKAY);
      chk({d3, d2, d1, d0}, 32'h0);
   endtask
   task automatic t_timing;
      wr(OFS_FINE_CORR, 32'hffff_ffff, RESP_OKAY);
      rd(OFS_FINE_CORR, 32'h0000_03ff, RESP_OKAY);
      chk(fine, 32'h3ff);
      wr(OFS_BASE_CORR, 32'hffff_ffff, RESP_OKAY);
      rd(OFS_BASE_CORR, 32'h07ff_ffff, RESP_OKAY);
      chk(base, 32'h07ff_ffff);
      wr(32'h4000_0070, 32'h1, RESP_DECERR);
      rd(32'h4000_0070, 32'h0, RESP_DECERR);
   endtask
   task automatic t_apply;
      wr(OFS_SLEEP_CONTROL, 32'h8, RESP_OKAY);
      repeat (4) @(posedge clk);
      chk(pulses, 1);
      rd(OFS_SLEEP_CONTROL, 32'h0, RESP_OKAY);
      wr(OFS_SLEEP_CONTROL, 32'h0, RESP_OKAY);
      repeat (4) @(posedge clk);
      chk(pulses, 1);
   endtask
   task automatic t_debug;
      wr(OFS_SW_PROFILE, 32'h4433_2211, RESP_OKAY);
      wr(OFS_DEBUG_CONTROL, 32'hbf03_8180, RESP_OKAY);
      rd(OFS_DEBUG_READBACK, 32'h0000_2211, RESP_OKAY);
      chk({d3, d2, d1, d0}, 32'h0000_2211);
      wr(OFS_DEBUG_CONTROL, 32'hbf83_8180, RESP_OKAY);
      rd(OFS_DEBUG_READBACK, 32'h0044_2211, RESP_OKAY);
   endtask
   task automatic t_zone;
      logic [15:0] ra[4] = '{16'h00ff, 16'h0100, 16'h0200, 16'h0201};
      logic [15:0] ea[4] = '{16'h07ff, 16'h0800, 16'h1000, 16'h1001};
      logic [1:0]  ex[4] = '{2'b00, 2'b11, 2'b11, 2'b00};
      wr(OFS_ZONE_UPPER, 32'h0200_1000, RESP_OKAY);
      wr(OFS_ZONE_LOWER, 32'h0100_0800, RESP_OKAY);
      rd(OFS_ZONE_UPPER, 32'h0200_1000, RESP_OKAY);
      foreach (ra[i]) begin
         @(posedge clk) begin zv <= 1; reg_a <= ra[i]; em_a <= ea[i]; end
         repeat (2) @(negedge clk);
         chk({reg_hit, em_hit}, ex[i]);
      end
      @(posedge clk) begin clk_en <= 0; reg_a <= 16'h0100; em_a <= 16'h0800; end
      repeat (2) @(negedge clk);
      chk({reg_hit, em_hit}, 2'b00);
      @(posedge clk) clk_en <= 1;
      repeat (2) @(negedge clk);
      chk({reg_hit, em_hit}, 2'b11);
      @(posedge clk) zv <= 0;
      repeat (2) @(negedge clk);
      chk({reg_hit, em_hit}, 2'b00);
   endtask
   task automatic fstep(input logic [31:0] e);
      repeat (3) @(posedge clk);
      rd(OFS_ERROR_FLAGS, e, RESP_OKAY);
   endtask
   task automatic t_faults;
      @(posedge clk) und <= 1;
      @(posedge clk) und <= 0;
      fstep(32'h400);
      @(posedge clk) hop <= 1;
      @(posedge clk) begin hop <= 0; ngood <= 6'h02; end
      fstep(32'h400);
      @(posedge clk) hop <= 1;
      @(posedge clk) begin hop <= 0; cs_bad <= 1; end
      @(posedge clk) begin cs_bad <= 0; adv <= 1; tx_dp <= 0; tx_dc <= 1; end
      @(posedge clk) begin tx_dc <= 0; rx_dp <= 0; rx_dc <= 1; end
      @(posedge clk) begin rx_dc <= 0; adv <= 0; conn <= 1; tx_bp <= 0; tx_bc <= 1; end
      @(posedge clk) tx_bc <= 0;
      fstep(32'h7c00);
      @(posedge clk) begin tx_len <= 8'h05; tx_bc <= 1; end
      @(posedge clk) begin tx_bc <= 0; rx_bp <= 0; rx_bc <= 1; end
      @(posedge clk) begin rx_bc <= 0; irq <= 1; end
      @(posedge clk) begin irq <= 0; ack <= 1; end
      @(posedge clk) begin ack <= 0; irq <= 1; end
      @(posedge clk) irq <= 0;
      fstep(32'h1_fc00);
      @(posedge clk) irq <= 1;
      @(posedge clk) irq <= 0;
      wr(OFS_ERROR_FLAGS, 32'h0, RESP_OKAY);
      fstep(32'h3_fc00);
   endtask
   task automatic t_select;
      strb <= 4'h2;
      wr(OFS_SW_PROFILE, 32'h0000_5500, RESP_OKAY);
      strb <= 4'hf;
      rd(OFS_SW_PROFILE, 32'h4433_5511, RESP_OKAY);
      wr(OFS_FINE_CORR, 32'h0000_01a5, RESP_OKAY);
      wr(OFS_DEBUG_CONTROL, 32'h8786_8584, RESP_OKAY);
      rd(OFS_DEBUG_READBACK, 32'hffa5_02ff, RESP_OKAY);
      chk({d3, d2, d1, d0}, 32'hffa5_02ff);
   endtask
   task automatic t_rerun;
      @(posedge clk) reset_n <= 0;
      repeat (2) @(posedge clk);
      reset_n <= 1;
      t_reset;
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      end_of_test;
   end
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1;
      t_reset;
      t_timing;
      t_apply;
      t_debug;
      t_zone;
      t_faults;
      t_select;
      t_rerun;
      end_of_test;
   end
endmodule
